// ==== test/boot_init_sequencer_props.sv ====
// Purpose: Port assertions for the start-up sequencer
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every sequencer instance

`timescale 1ns/1ps

// ========================================
// Checker
module boot_init_sequencer_props #(
    parameter int W = 32
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic localCpuNumber,
    input wire logic bootLeaderSelect,
    input wire logic selfTestRun,
    input wire logic selfTestDone,
    input wire logic selfTestPass,
    input wire logic selfTestFailOut,
    input wire logic memReq,
    input wire logic [W-1:0] memAddr,
    input wire logic memAck,
    input wire logic reinitReq,
    input wire logic [W-1:0] reinitTableBase,
    input wire logic [W-1:0] reinitControlBase,
    input wire logic reinitAccept,
    input wire logic serviceStart,
    input wire logic nonMessageIrq,
    input wire logic modifyControlsExec,
    input wire logic priorityWriteStrobe,
    input wire logic [boot_init_pkg::PRIO_W-1:0] priorityWriteValue,
    input wire logic cpuNumber,
    input wire logic clearLatchedRequests,
    input wire logic beginExecution,
    input wire boot_init_pkg::boot_ptrs_s bootPtrs,
    input wire boot_init_pkg::proc_ctrl_s procCtrl
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_pass;
        selfTestRun && selfTestDone && selfTestPass;
    endsequence
    sequence s_fail;
        selfTestRun && selfTestDone && !selfTestPass;
    endsequence

    a_fail_in_test: assert property (selfTestRun |-> selfTestFailOut)
        else $error("fail output low in self test");
    a_pass_clears: assert property (s_pass |=> !selfTestFailOut && !selfTestRun)
        else $error("pass did not clear fail output");
    a_fail_stops: assert property (s_fail |=> selfTestFailOut && !memReq && procCtrl.state == boot_init_pkg::PS_STOPPED)
        else $error("failed self test did not stop");
    a_leader_go: assert property (s_pass ##1 bootLeaderSelect |=> memReq && memAddr == 32'h0)
        else $error("leader did not read address zero");
    a_leader_stop: assert property (s_pass ##1 !bootLeaderSelect |=> !memReq [*4])
        else $error("non-leader read memory");
    a_addr_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("read dropped before ack");
    a_begin_clean: assert property (beginExecution |-> clearLatchedRequests ##1 !beginExecution)
        else $error("begin without clearing requests");
    a_begin_preset: assert property (beginExecution |-> ##[0:1] (procCtrl.state == boot_init_pkg::PS_INTERRUPTED
        && procCtrl.prio == 5'h1F && procCtrl.supervisorMode && procCtrl.traceControls == 8'h00
        && !procCtrl.breakpointEnable))
        else $error("controls not preset at begin");
    a_fail_rise_stop: assert property ($rose(selfTestFailOut) |-> ##[0:1] procCtrl.state == boot_init_pkg::PS_STOPPED)
        else $error("fail output rose without stop");
    a_prio_write: assert property (priorityWriteStrobe |-> ($past(nonMessageIrq) || $past(modifyControlsExec))
        && $past(bootPtrs.writeExtPriority) && priorityWriteValue == $past(procCtrl.prio))
        else $error("bad priority write");
    a_reinit_load: assert property (reinitReq && reinitAccept |=> memReq && memAddr == $past(reinitControlBase) + 32'h4
        && bootPtrs.addressTableBase == $past(reinitTableBase))
        else $error("reinit did not reload pointers");
    a_cpu_strap: assert property ($rose(rst_n) |-> cpuNumber == $past(localCpuNumber))
        else $error("cpu number not sampled in reset");
    a_stop_service: assert property (procCtrl.state == boot_init_pkg::PS_STOPPED && serviceStart && !reinitReq
        |=> procCtrl.state == boot_init_pkg::PS_STOPPED_INT)
        else $error("service did not leave stop");
endmodule

bind boot_init_sequencer boot_init_sequencer_props #(.W(W)) u_boot_props (.*);

// ==== test/boot_init_sequencer_test.sv ====
// Purpose: Self-checking bench for the start-up sequencer
// Assumes: Inputs driven at the falling edge
// Notes: Image words are placed straight into the memory model

`timescale 1ns/1ps

module boot_init_sequencer_test;
    logic clk_sys = 1'b0, rst_n = 1'b0, localCpuNumber = 1'b0, bootLeaderSelect = 1'b0;
    logic selfTestDone = 1'b0, selfTestPass = 1'b0, reinitReq = 1'b0, serviceStart = 1'b0;
    logic serviceDone = 1'b0, nonMessageIrq = 1'b0, modifyControlsExec = 1'b0, prioLoad = 1'b0;
    logic [4:0] prioLoadValue = 5'h00, priorityWriteValue;
    logic [31:0] reinitTableBase = 32'h0, reinitControlBase = 32'h0, memAddr, memData;
    logic [3:0] memWait = 4'h0;
    logic selfTestRun, selfTestFailOut, memReq, memAck, reinitAccept, priorityWriteStrobe, seen;
    logic cpuNumber, flagReservedError, clearLatchedRequests, beginExecution;
    boot_init_pkg::boot_ptrs_s bootPtrs;
    boot_init_pkg::proc_ctrl_s procCtrl;
    int fails = 0, n_checks = 0;
    localparam boot_init_pkg::proc_ctrl_s presetCtrl = '{boot_init_pkg::PS_INTERRUPTED, 5'h1F, 1'b1, 8'h00, 1'b0};

    boot_init_sequencer i_boot_init_sequencer (.clk_sys(clk_sys), .rst_n(rst_n), .localCpuNumber(localCpuNumber),
        .bootLeaderSelect(bootLeaderSelect), .selfTestRun(selfTestRun), .selfTestDone(selfTestDone),
        .selfTestPass(selfTestPass), .selfTestFailOut(selfTestFailOut), .memReq(memReq), .memAddr(memAddr),
        .memAck(memAck), .memData(memData), .reinitReq(reinitReq), .reinitTableBase(reinitTableBase),
        .reinitControlBase(reinitControlBase), .reinitAccept(reinitAccept), .serviceStart(serviceStart),
        .serviceDone(serviceDone), .nonMessageIrq(nonMessageIrq), .modifyControlsExec(modifyControlsExec),
        .prioLoad(prioLoad), .prioLoadValue(prioLoadValue), .priorityWriteStrobe(priorityWriteStrobe),
        .priorityWriteValue(priorityWriteValue), .cpuNumber(cpuNumber), .flagReservedError(flagReservedError),
        .clearLatchedRequests(clearLatchedRequests), .beginExecution(beginExecution), .bootPtrs(bootPtrs),
        .procCtrl(procCtrl));
    boot_mem_model i_boot_mem_model (.clk_sys(clk_sys), .memReq(memReq), .memAddr(memAddr),
        .waitCycles(memWait), .memAck(memAck), .memData(memData));

    initial forever #5 clk_sys = ~clk_sys;

    // ========================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chkb(input string what, input logic e, input logic g);
        chk(what, {31'h0, e}, {31'h0, g});
    endtask
    task automatic chk_state(input boot_init_pkg::proc_state_e e);
        chk("state", 32'(e), 32'(procCtrl.state));
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic boot(input logic cpu, input logic pass, input logic leader);
        rst_n = 1'b0;
        localCpuNumber = cpu;
        bootLeaderSelect = leader;
        cyc(20);
        rst_n = 1'b1;
        cyc(2);
        chkb("selfTestRun", 1'b1, selfTestRun);
        selfTestPass = pass;
        selfTestDone = 1'b1;
        cyc(1);
        selfTestDone = 1'b0;
    endtask
    task automatic load_image(input logic bad);
        logic [31:0] w [0:6];
        logic [32:0] t;
        logic [31:0] acc;
        logic c;
        w = '{32'h0000_0100, 32'h0000_0040, 32'hA5A5_0002, 32'h0000_2000, 32'h0F0F_0004, 32'hFFFF_FFF5, 32'h8000_0006};
        acc = 32'hFFFF_FFFF;
        c = 1'b1;
        for (int i = 0; i < 7; i++) begin
            i_boot_mem_model.mem[i] = w[i];
            t = {1'b0, acc} + {1'b0, w[i]} + {32'h0, c};
            acc = t[31:0];
            c = t[32];
        end
        i_boot_mem_model.mem[7] = 32'h0 - acc - {31'h0, c} + {31'h0, bad};
        i_boot_mem_model.mem[98] = w[0];
        i_boot_mem_model.mem[99] = 32'h00FC_00FB;
        i_boot_mem_model.mem[102] = 32'h0000_0400;
        i_boot_mem_model.mem[103] = 32'h3044_00FB;
    endtask
    task automatic load_cb(input logic [31:0] cb, input logic [31:0] flag, input logic [31:0] isp);
        i_boot_mem_model.mem[cb[7:2] + 6'd1] = flag;
        i_boot_mem_model.mem[cb[7:2] + 6'd6] = isp;
    endtask
    task automatic wait_begin(output logic found);
        found = 1'b0;
        for (int i = 0; i < 200 && !found; i++) begin
            @(posedge clk_sys);
            #1;
            found = (beginExecution === 1'b1);
        end
        if (found)
            chkb("clearLatchedRequests", 1'b1, clearLatchedRequests);
        cyc(2);
    endtask
    task automatic reinit(input logic [31:0] tb, input logic [31:0] cb);
        reinitTableBase = tb;
        reinitControlBase = cb;
        reinitReq = 1'b1;
        #1 chkb("reinitAccept", 1'b1, reinitAccept);
        cyc(1);
        reinitReq = 1'b0;
    endtask
    task automatic pulse_irq(input logic irq, input logic expStrobe);
        nonMessageIrq = irq;
        modifyControlsExec = !irq;
        cyc(1);
        nonMessageIrq = 1'b0;
        modifyControlsExec = 1'b0;
        chkb("priorityWriteStrobe", expStrobe, priorityWriteStrobe);
        if (expStrobe)
            chk("priorityWriteValue", 32'h5, 32'(priorityWriteValue));
    endtask
    task automatic chk_ptrs(input logic [31:0] tb, input logic [31:0] cb, input logic [31:0] fp);
        chk("tableBase", tb, bootPtrs.addressTableBase);
        chk("controlBase", cb, bootPtrs.controlBlockBase);
        chk("startIp", 32'h0000_2000, bootPtrs.startIp);
        chk("framePointer", fp, bootPtrs.framePointer);
    endtask

    // ========================================
    // Tests
    initial begin
        boot(1'b1, 1'b0, 1'b1);
        cyc(10);
        chkb("cpuNumber", 1'b1, cpuNumber);
        chkb("failOut", 1'b1, selfTestFailOut);
        chkb("memReq", 1'b0, memReq);
        chk_state(boot_init_pkg::PS_STOPPED);
        boot(1'b0, 1'b1, 1'b0);
        cyc(10);
        chkb("cpuNumber", 1'b0, cpuNumber);
        chkb("failOut", 1'b0, selfTestFailOut);
        chkb("memReq", 1'b0, memReq);
        chk_state(boot_init_pkg::PS_STOPPED);
        load_image(1'b0);
        load_cb(32'h0000_0040, 32'h8000_0000, 32'h0000_3000);
        memWait = 4'h2;
        boot(1'b1, 1'b1, 1'b1);
        wait_begin(seen);
        chkb("begin", 1'b1, seen);
        chk_ptrs(32'h0000_0100, 32'h0000_0040, 32'h0000_3000);
        chkb("writeExtPriority", 1'b1, bootPtrs.writeExtPriority);
        chkb("flagReservedError", 1'b0, flagReservedError);
        chkb("failOut", 1'b0, selfTestFailOut);
        chk("procCtrl", 32'(presetCtrl), 32'(procCtrl));
        prioLoadValue = 5'h05;
        prioLoad = 1'b1;
        cyc(1);
        prioLoad = 1'b0;
        pulse_irq(1'b1, 1'b1);
        pulse_irq(1'b0, 1'b1);
        i_boot_mem_model.mem[3] = 32'h0000_2400;
        load_cb(32'h0000_0080, 32'h0000_0001, 32'h0000_5000);
        memWait = 4'h0;
        reinit(32'h0000_0200, 32'h0000_0080);
        wait_begin(seen);
        chkb("begin", 1'b1, seen);
        chk_ptrs(32'h0000_0200, 32'h0000_0080, 32'h0000_5000);
        chkb("writeExtPriority", 1'b0, bootPtrs.writeExtPriority);
        chkb("flagReservedError", 1'b1, flagReservedError);
        pulse_irq(1'b1, 1'b0);
        load_image(1'b1);
        boot(1'b0, 1'b1, 1'b1);
        wait_begin(seen);
        chkb("begin", 1'b0, seen);
        chkb("failOut", 1'b1, selfTestFailOut);
        chk_state(boot_init_pkg::PS_STOPPED);
        serviceStart = 1'b1;
        cyc(1);
        serviceStart = 1'b0;
        chk_state(boot_init_pkg::PS_STOPPED_INT);
        serviceDone = 1'b1;
        cyc(1);
        serviceDone = 1'b0;
        chk_state(boot_init_pkg::PS_STOPPED);
        reinit(32'h0000_0100, 32'h0000_0040);
        wait_begin(seen);
        chkb("begin", 1'b1, seen);
        print_verdict;
    end

    initial begin
        #100000;
        fails++;
        print_verdict;
    end
endmodule

// ==== test/boot_mem_model.sv ====
// Purpose: Local bus memory holding the start-up image
// Assumes: One word per ack, ack a one-cycle pulse
// Notes: Idle data toggles so stale words never look valid

`timescale 1ns/1ps

// ========================================
// Memory
module boot_mem_model (
    input wire logic clk_sys,
    input wire logic memReq,
    input wire logic [31:0] memAddr,
    input wire logic [3:0] waitCycles,
    output logic memAck,
    output logic [31:0] memData
);
    logic [31:0] mem [0:127];
    logic [3:0] cnt = 4'h0;

    initial {memAck, memData} = 33'h0;

    always @(posedge clk_sys) begin
        if (memAck) begin
            memAck <= 1'b0;
            memData <= ~memData;
            cnt <= 4'h0;
        end else if (memReq && cnt >= waitCycles) begin
            memAck <= 1'b1;
            memData <= mem[memAddr[8:2]];
        end else if (memReq) begin
            cnt <= cnt + 4'h1;
        end else begin
            cnt <= 4'h0;
            memData <= ~memData;
        end
    end
endmodule

// ==== verilog/boot_init_pkg.sv ====
// Purpose: Shared constants and types for the start-up sequencer
// Assumes: 32-bit local bus, word reads only
// Notes: Byte offsets are addresses on the local bus

package boot_init_pkg;

    // ========================================
    // Widths and counts
    localparam int WORD_W = 32;
    localparam int CHECK_WORDS = 8;
    localparam int IDX_W = 3;
    localparam int PRIO_W = 5;
    localparam int TRACE_W = 8;

    // ========================================
    // Check words
    localparam logic [WORD_W-1:0] CHECK_BASE_ADDR = 32'h0000_0000;
    localparam logic [WORD_W-1:0] CHECK_SEED = 32'hFFFF_FFFF;
    localparam logic CHECK_CARRY_SEED = 1'b1;
    localparam logic [IDX_W-1:0] IDX_SAT_BASE = 3'h0;
    localparam logic [IDX_W-1:0] IDX_PRCB_BASE = 3'h1;
    localparam logic [IDX_W-1:0] IDX_START_IP = 3'h3;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
    localparam logic [WORD_W-1:0] WORD_BYTES = 32'h0000_0004;

    // ========================================
    // Control block layout
    localparam logic [WORD_W-1:0] PRCB_FLAG_OFS = 32'h0000_0004;
    localparam logic [WORD_W-1:0] PRCB_ISP_OFS = 32'h0000_0018;
    localparam int WEP_BIT = 31;

    // ========================================
    // Reset and preset values
    localparam logic [PRIO_W-1:0] PRIO_MAX = 5'h1F;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 5'h00;
    localparam logic [TRACE_W-1:0] TRACE_RESET = 8'h00;
    localparam logic [WORD_W-1:0] PTR_RESET = 32'h0000_0000;

    // ========================================
    // Types
    typedef enum logic [9:0] {
        ST_SELF_TEST   = 10'h001,
        ST_STRAP       = 10'h002,
        ST_READ_CHECK  = 10'h004,
        ST_EVAL        = 10'h008,
        ST_READ_FLAG   = 10'h010,
        ST_READ_ISP    = 10'h020,
        ST_START       = 10'h040,
        ST_RUNNING     = 10'h080,
        ST_STOPPED     = 10'h100,
        ST_STOPPED_INT = 10'h200
    } seq_state_e;

    typedef enum logic [3:0] {
        PS_EXECUTING   = 4'h1,
        PS_INTERRUPTED = 4'h2,
        PS_STOPPED     = 4'h4,
        PS_STOPPED_INT = 4'h8
    } proc_state_e;

    typedef struct packed {
        proc_state_e state;
        logic [PRIO_W-1:0] prio;
        logic supervisorMode;
        logic [TRACE_W-1:0] traceControls;
        logic breakpointEnable;
    } proc_ctrl_s;

    typedef struct packed {
        logic [WORD_W-1:0] addressTableBase;
        logic [WORD_W-1:0] controlBlockBase;
        logic [WORD_W-1:0] startIp;
        logic [WORD_W-1:0] framePointer;
        logic writeExtPriority;
    } boot_ptrs_s;

endpackage

// ==== verilog/boot_init_sequencer.sv ====
// Purpose: Start-up sequencer: self test, strap check, check words, control block load
// Assumes: Single-word reads on the local bus, memAck one cycle pulse per read
// Notes: Reinitialize message reloads the control block and restarts execution

`timescale 1ns/1ps

module boot_init_sequencer #(
    parameter int W = boot_init_pkg::WORD_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic localCpuNumber,
    input wire logic bootLeaderSelect,
    output logic selfTestRun,
    input wire logic selfTestDone,
    input wire logic selfTestPass,
    output logic selfTestFailOut,
    output logic memReq,
    output logic [W-1:0] memAddr,
    input wire logic memAck,
    input wire logic [W-1:0] memData,
    input wire logic reinitReq,
    input wire logic [W-1:0] reinitTableBase,
    input wire logic [W-1:0] reinitControlBase,
    output logic reinitAccept,
    input wire logic serviceStart,
    input wire logic serviceDone,
    input wire logic nonMessageIrq,
    input wire logic modifyControlsExec,
    input wire logic prioLoad,
    input wire logic [boot_init_pkg::PRIO_W-1:0] prioLoadValue,
    output logic priorityWriteStrobe,
    output logic [boot_init_pkg::PRIO_W-1:0] priorityWriteValue,
    output logic cpuNumber,
    output logic flagReservedError,
    output logic clearLatchedRequests,
    output logic beginExecution,
    output boot_init_pkg::boot_ptrs_s bootPtrs,
    output boot_init_pkg::proc_ctrl_s procCtrl
);

    boot_init_pkg::seq_state_e state_reg;
    boot_init_pkg::seq_state_e state_next;
    logic [boot_init_pkg::IDX_W-1:0] wordIdx_reg;
    logic [W-1:0] memAddr_reg;
    logic [W-1:0] memAddr_next;
    logic failOut_reg;
    logic cpuNumber_reg;
    logic flagErr_reg;
    logic clearLatched_reg;
    logic begin_reg;
    logic prioWr_reg;
    logic [boot_init_pkg::PRIO_W-1:0] prioWrVal_reg;
    boot_init_pkg::boot_ptrs_s ptrs_reg;
    boot_init_pkg::proc_ctrl_s ctrl_reg;
    logic checkClear;
    logic checkAdd;
    logic checkZero;
    logic reinitTake;
    logic lastCheck;

    // ========================================
    // Check sum accumulator
    checksum_acc #(
        .W(W)
    ) u_checksum (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clear(checkClear),
        .addEn(checkAdd),
        .word(memData),
        .sum(),
        .isZero(checkZero)
    );

    assign checkClear = (state_reg == boot_init_pkg::ST_STRAP);
    assign checkAdd = (state_reg == boot_init_pkg::ST_READ_CHECK) && memAck;
    assign lastCheck = (wordIdx_reg == boot_init_pkg::IDX_LAST);

    // ========================================
    // Reinitialize acceptance
    always_comb begin
        reinitTake = reinitReq && ((state_reg == boot_init_pkg::ST_RUNNING) ||
                                   (state_reg == boot_init_pkg::ST_STOPPED) ||
                                   (state_reg == boot_init_pkg::ST_STOPPED_INT));
    end

    assign reinitAccept = reinitTake;

    // ========================================
    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            boot_init_pkg::ST_SELF_TEST: begin
                if (selfTestDone) begin
                    state_next = selfTestPass ? boot_init_pkg::ST_STRAP : boot_init_pkg::ST_STOPPED;
                end
            end
            boot_init_pkg::ST_STRAP: begin
                state_next = bootLeaderSelect ? boot_init_pkg::ST_READ_CHECK : boot_init_pkg::ST_STOPPED;
            end
            boot_init_pkg::ST_READ_CHECK: begin
                if (memAck && lastCheck) begin
                    state_next = boot_init_pkg::ST_EVAL;
                end
            end
            boot_init_pkg::ST_EVAL: begin
                state_next = checkZero ? boot_init_pkg::ST_READ_FLAG : boot_init_pkg::ST_STOPPED;
            end
            boot_init_pkg::ST_READ_FLAG: begin
                if (memAck) begin
                    state_next = boot_init_pkg::ST_READ_ISP;
                end
            end
            boot_init_pkg::ST_READ_ISP: begin
                if (memAck) begin
                    state_next = boot_init_pkg::ST_START;
                end
            end
            boot_init_pkg::ST_START: begin
                state_next = boot_init_pkg::ST_RUNNING;
            end
            boot_init_pkg::ST_RUNNING: begin
                if (reinitTake) begin
                    state_next = boot_init_pkg::ST_READ_FLAG;
                end
            end
            boot_init_pkg::ST_STOPPED: begin
                if (reinitTake) begin
                    state_next = boot_init_pkg::ST_READ_FLAG;
                end else if (serviceStart) begin
                    state_next = boot_init_pkg::ST_STOPPED_INT;
                end
            end
            boot_init_pkg::ST_STOPPED_INT: begin
                if (reinitTake) begin
                    state_next = boot_init_pkg::ST_READ_FLAG;
                end else if (serviceDone) begin
                    state_next = boot_init_pkg::ST_STOPPED;
                end
            end
            default: begin
                state_next = boot_init_pkg::ST_STOPPED;
            end
        endcase
    end

    // Reset restarts the whole sequence
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= boot_init_pkg::ST_SELF_TEST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ========================================
    // Strap capture while reset is held
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cpuNumber_reg <= localCpuNumber;
        end
    end

    // ========================================
    // Self_test_fail_out output
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            failOut_reg <= 1'b1;
        end else if (state_reg == boot_init_pkg::ST_SELF_TEST && selfTestDone && selfTestPass) begin
            failOut_reg <= 1'b0;
        end else if (state_reg == boot_init_pkg::ST_EVAL && !checkZero) begin
            failOut_reg <= 1'b1;
        end
    end

    // ========================================
    // Word index and read address
    always_ff @(posedge clk_sys) begin
        if (!rst_n || state_reg == boot_init_pkg::ST_STRAP) begin
            wordIdx_reg <= '0;
        end else if (checkAdd) begin
            wordIdx_reg <= wordIdx_reg + 3'h1;
        end
    end

    always_comb begin
        memAddr_next = memAddr_reg;
        case (state_next)
            boot_init_pkg::ST_READ_CHECK: begin
                if (state_reg != boot_init_pkg::ST_READ_CHECK) begin
                    memAddr_next = boot_init_pkg::CHECK_BASE_ADDR;
                end else if (memAck) begin
                    memAddr_next = memAddr_reg + boot_init_pkg::WORD_BYTES;
                end
            end
            boot_init_pkg::ST_READ_FLAG: begin
                if (reinitTake) begin
                    memAddr_next = reinitControlBase + boot_init_pkg::PRCB_FLAG_OFS;
                end else begin
                    memAddr_next = ptrs_reg.controlBlockBase + boot_init_pkg::PRCB_FLAG_OFS;
                end
            end
            boot_init_pkg::ST_READ_ISP: begin
                memAddr_next = ptrs_reg.controlBlockBase + boot_init_pkg::PRCB_ISP_OFS;
            end
            default: begin
                memAddr_next = memAddr_reg;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            memAddr_reg <= boot_init_pkg::CHECK_BASE_ADDR;
        end else begin
            memAddr_reg <= memAddr_next;
        end
    end

    // ========================================
    // Cached pointers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ptrs_reg <= '0;
            flagErr_reg <= 1'b0;
        end else begin
            if (checkAdd && wordIdx_reg == boot_init_pkg::IDX_SAT_BASE) begin
                ptrs_reg.addressTableBase <= memData;
            end
            if (checkAdd && wordIdx_reg == boot_init_pkg::IDX_PRCB_BASE) begin
                ptrs_reg.controlBlockBase <= memData;
            end
            if (checkAdd && wordIdx_reg == boot_init_pkg::IDX_START_IP) begin
                ptrs_reg.startIp <= memData;
            end
            if (reinitTake) begin
                ptrs_reg.addressTableBase <= reinitTableBase;
                ptrs_reg.controlBlockBase <= reinitControlBase;
            end
            if (state_reg == boot_init_pkg::ST_READ_FLAG && memAck) begin
                ptrs_reg.writeExtPriority <= memData[boot_init_pkg::WEP_BIT];
                flagErr_reg <= (memData[boot_init_pkg::WEP_BIT-1:0] != '0);
            end
            if (state_reg == boot_init_pkg::ST_READ_ISP && memAck) begin
                ptrs_reg.framePointer <= memData;
            end
        end
    end

    // ========================================
    // Processor controls
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_reg.state <= boot_init_pkg::PS_STOPPED;
            ctrl_reg.prio <= boot_init_pkg::PRIO_RESET;
            ctrl_reg.supervisorMode <= 1'b0;
            ctrl_reg.traceControls <= boot_init_pkg::TRACE_RESET;
            ctrl_reg.breakpointEnable <= 1'b0;
        end else if (state_reg == boot_init_pkg::ST_START) begin
            ctrl_reg.state <= boot_init_pkg::PS_INTERRUPTED;
            ctrl_reg.prio <= boot_init_pkg::PRIO_MAX;
            ctrl_reg.supervisorMode <= 1'b1;
            ctrl_reg.traceControls <= boot_init_pkg::TRACE_RESET;
            ctrl_reg.breakpointEnable <= 1'b0;
        end else begin
            if (state_next == boot_init_pkg::ST_STOPPED) begin
                ctrl_reg.state <= boot_init_pkg::PS_STOPPED;
            end else if (state_next == boot_init_pkg::ST_STOPPED_INT) begin
                ctrl_reg.state <= boot_init_pkg::PS_STOPPED_INT;
            end
            if (prioLoad && state_reg == boot_init_pkg::ST_RUNNING) begin
                ctrl_reg.prio <= prioLoadValue;
            end
        end
    end

    // ========================================
    // Start pulses
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            clearLatched_reg <= 1'b0;
            begin_reg <= 1'b0;
        end else begin
            clearLatched_reg <= (state_reg == boot_init_pkg::ST_START);
            begin_reg <= (state_reg == boot_init_pkg::ST_START);
        end
    end

    // ========================================
    // External priority write
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prioWr_reg <= 1'b0;
            prioWrVal_reg <= boot_init_pkg::PRIO_RESET;
        end else begin
            prioWr_reg <= ptrs_reg.writeExtPriority && (state_reg == boot_init_pkg::ST_RUNNING) &&
                          (nonMessageIrq || modifyControlsExec);
            if (ptrs_reg.writeExtPriority && (nonMessageIrq || modifyControlsExec)) begin
                prioWrVal_reg <= ctrl_reg.prio;
            end
        end
    end

    // ========================================
    // Outputs
    assign selfTestRun = (state_reg == boot_init_pkg::ST_SELF_TEST);
    assign selfTestFailOut = failOut_reg;
    assign memReq = (state_reg == boot_init_pkg::ST_READ_CHECK) ||
                    (state_reg == boot_init_pkg::ST_READ_FLAG) ||
                    (state_reg == boot_init_pkg::ST_READ_ISP);
    assign memAddr = memAddr_reg;
    assign priorityWriteStrobe = prioWr_reg;
    assign priorityWriteValue = prioWrVal_reg;
    assign cpuNumber = cpuNumber_reg;
    assign flagReservedError = flagErr_reg;
    assign clearLatchedRequests = clearLatched_reg;
    assign beginExecution = begin_reg;
    assign bootPtrs = ptrs_reg;
    assign procCtrl = ctrl_reg;

endmodule

// ==== verilog/checksum_acc.sv ====
// Purpose: Add-with-carry accumulator for the check words
// Assumes: One word per addEn pulse
// Notes: Clear reloads the all-ones seed with carry set

`timescale 1ns/1ps

module checksum_acc #(
    parameter int W = 32
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic addEn,
    input wire logic [W-1:0] word,
    output logic [W-1:0] sum,
    output logic isZero
);

    logic [W-1:0] sum_reg;
    logic carry_reg;
    logic [W:0] total;

    // ========================================
    // Accumulate
    always_comb begin
        total = {1'b0, sum_reg} + {1'b0, word} + {{W{1'b0}}, carry_reg};
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || clear) begin
            sum_reg <= boot_init_pkg::CHECK_SEED;
            carry_reg <= boot_init_pkg::CHECK_CARRY_SEED;
        end else if (addEn) begin
            sum_reg <= total[W-1:0];
            carry_reg <= total[W];
        end
    end

    assign sum = sum_reg;
    assign isZero = (sum_reg == '0);

endmodule
